// ==== rlt_router_timing.sv ====
`timescale 1ns/1ps
// What this block does
// - A finished output packet lets a waiting input be connected within four clocks.
// - A received data character clears the output port empty flag within 5 rx + 8 sys.
// - A character written to input port A leaves the transmitter within 4 sys + 23 tx.
// - A character written to one external port shows at the other within five clocks.
// - A received time-code is fully retransmitted within 5 rx + 6 sys + 16 tx periods.
// - A received time-code raises the tick output within 5 rx + 8 sys periods.
// - A tick input rising edge gives a sent time-code within 6 sys + 16 tx periods.
// - A waiting time-code is held back by at most one data character.
// - Each tick output pulse is four clocks high then three low, value at the fall.
// - One transmit or receive clock period spans two bit periods.
// - Full, empty and read data change only on rising clock edges.
// - Received time-codes reach the external interface only when it is enabled.
module rlt_router_timing
    import rlt_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // External input port to serial transmitter
    input wire logic extAWrEn,
    input wire rlt_char_s extAWrData,
    output logic extAFull,
    // External input port to external output port
    input wire logic extBWrEn,
    input wire rlt_char_s extBWrData,
    output logic extBFull,
    // External output port
    input wire logic extRdEn,
    output rlt_char_s extRdData,
    output logic extEmpty,
    // Time-code interface
    input wire logic external_time_pulse_input,
    input wire logic time_counter_clear_input,
    input wire logic tcExtEnable,
    output logic external_time_pulse_output,
    output rlt_tc_s tcOutValue,
    // Serial receiver pins
    input wire logic rxLinkClk,
    input wire logic rxLinkFrame,
    input wire logic rxLinkBit,
    // Serial transmitter pins
    output logic txLinkClk,
    output logic txLinkFrame,
    output logic txLinkBit
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [4:0] pinRaw;
    logic [4:0] pinS1_q, pinS2_q, pinS3_q;

    assign pinRaw = {time_counter_clear_input, external_time_pulse_input,
                     rxLinkBit, rxLinkFrame, rxLinkClk};

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pinS1_q <= 5'h00;
            pinS2_q <= 5'h00;
            pinS3_q <= 5'h00;
        end else begin
            pinS1_q <= pinRaw;
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
        end
    end

    logic linkEdge, tickInRise, timeClr, rxFrame, rxBit;
    assign linkEdge = pinS2_q[0] ^ pinS3_q[0];
    assign rxFrame = pinS2_q[1];
    assign rxBit = pinS2_q[2];
    assign tickInRise = rose(pinS2_q[3], pinS3_q[3]);
    assign timeClr = pinS2_q[4];

    // ----------------------------------------
    // Serial receiver
    // ----------------------------------------
    logic [CHAR_BITS-1:0] rxShift_q, rxShift_d, rxWord;
    logic [CNT_W-1:0] rxCnt_q, rxCnt_d;
    rlt_char_s rxHold_q, rxHold_d;
    logic rxHoldValid_q, rxHoldValid_d;
    rlt_tc_s rxTc_q, rxTc_d;
    logic rxTcEvt_q, rxTcEvt_d;
    logic rxPop;

    assign rxWord = {rxBit, rxShift_q[CHAR_BITS-1:1]};

    always_comb begin
        rxShift_d = rxShift_q;
        rxCnt_d = rxCnt_q;
        rxHold_d = rxHold_q;
        rxHoldValid_d = rxHoldValid_q & ~rxPop;
        rxTc_d = rxTc_q;
        rxTcEvt_d = 1'b0;
        if (!rxFrame) begin
            rxCnt_d = 4'h0;
        end else if (linkEdge) begin
            rxShift_d = rxWord;
            rxCnt_d = rxCnt_q + 4'h1;
            if (rxCnt_q == LAST_BIT) begin
                rxCnt_d = 4'h0;
                if (rxWord[KIND_POS]) begin
                    rxTc_d = rxWord[8:1];
                    rxTcEvt_d = 1'b1;
                end else if (!rxHoldValid_d) begin
                    rxHold_d = rxWord[9:1];
                    rxHoldValid_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxShift_q <= 10'h000;
            rxCnt_q <= 4'h0;
            rxHold_q <= CHAR_RESET;
            rxHoldValid_q <= 1'b0;
            rxTc_q <= TC_RESET;
            rxTcEvt_q <= 1'b0;
        end else begin
            rxShift_q <= rxShift_d;
            rxCnt_q <= rxCnt_d;
            rxHold_q <= rxHold_d;
            rxHoldValid_q <= rxHoldValid_d;
            rxTc_q <= rxTc_d;
            rxTcEvt_q <= rxTcEvt_d;
        end
    end

    // ----------------------------------------
    // External input holds
    // ----------------------------------------
    rlt_char_s extA_q, extA_d, extB_q, extB_d;
    logic extAValid_q, extAValid_d, extBValid_q, extBValid_d;
    logic extAPop, extBPop;

    always_comb begin
        extA_d = extA_q;
        extB_d = extB_q;
        extAValid_d = extAValid_q & ~extAPop;
        extBValid_d = extBValid_q & ~extBPop;
        if (extAWrEn && !extAValid_q) begin
            extA_d = extAWrData;
            extAValid_d = 1'b1;
        end
        if (extBWrEn && !extBValid_q) begin
            extB_d = extBWrData;
            extBValid_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            extA_q <= CHAR_RESET;
            extB_q <= CHAR_RESET;
            extAValid_q <= 1'b0;
            extBValid_q <= 1'b0;
        end else begin
            extA_q <= extA_d;
            extB_q <= extB_d;
            extAValid_q <= extAValid_d;
            extBValid_q <= extBValid_d;
        end
    end

    assign extAFull = extAValid_q;
    assign extBFull = extBValid_q;

    // ----------------------------------------
    // Output port arbiter and queue
    // ----------------------------------------
    rlt_arb_e arb_q, arb_d;
    logic lastRx_q, lastRx_d;
    logic [FIFO_AW:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic empty_q, empty_d;
    logic qFull, push, pop;
    rlt_char_s pushData;

    assign qFull = (wrPtr_q[FIFO_AW] != rdPtr_q[FIFO_AW])
                   && (wrPtr_q[FIFO_AW-1:0] == rdPtr_q[FIFO_AW-1:0]);
    // read enable taken at the edge
    assign pop = extRdEn & ~empty_q;

    always_comb begin
        arb_d = arb_q;
        lastRx_d = lastRx_q;
        push = 1'b0;
        pushData = extB_q;
        rxPop = 1'b0;
        extBPop = 1'b0;
        unique case (arb_q)
            ARB_IDLE: begin
                if (rxHoldValid_q && (!extBValid_q || !lastRx_q)) begin
                    arb_d = ARB_RX;
                    lastRx_d = 1'b1;
                end else if (extBValid_q) begin
                    arb_d = ARB_EXT;
                    lastRx_d = 1'b0;
                end
            end
            ARB_RX: begin
                pushData = rxHold_q;
                if (rxHoldValid_q && !qFull) begin
                    push = 1'b1;
                    rxPop = 1'b1;
                    if (rxHold_q.eop) begin
                        arb_d = ARB_IDLE;
                    end
                end
            end
            ARB_EXT: begin
                // port to port in few clocks
                if (extBValid_q && !qFull) begin
                    push = 1'b1;
                    extBPop = 1'b1;
                    if (extB_q.eop) begin
                        arb_d = ARB_IDLE;
                    end
                end
            end
        endcase
        wrPtr_d = wrPtr_q + (FIFO_AW+1)'(push);
        rdPtr_d = rdPtr_q + (FIFO_AW+1)'(pop);
        empty_d = (wrPtr_d == rdPtr_d);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            arb_q <= ARB_IDLE;
            lastRx_q <= 1'b0;
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            empty_q <= 1'b1;
        end else begin
            arb_q <= arb_d;
            lastRx_q <= lastRx_d;
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            empty_q <= empty_d;
        end
    end

    assign extEmpty = empty_q;

    rlt_char_mem u_mem (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .wrEn(push),
        .wrAddr(wrPtr_q[FIFO_AW-1:0]),
        .wrData(pushData),
        .rdEn(pop),
        .rdAddr(rdPtr_q[FIFO_AW-1:0]),
        .rdData(extRdData)
    );

    // ----------------------------------------
    // Time-code handling
    // ----------------------------------------
    rlt_tc_s time_q, time_d, txTc_q, txTc_d;
    logic txTcPend_q, txTcPend_d, txTcTake;
    logic extEvt;

    assign extEvt = rxTcEvt_q & tcExtEnable;

    always_comb begin
        time_d = time_q;
        txTc_d = txTc_q;
        txTcPend_d = txTcPend_q & ~txTcTake;
        if (timeClr) begin
            time_d = TC_RESET;
        end else if (rxTcEvt_q) begin
            time_d = rxTc_q;
            txTc_d = rxTc_q;
            txTcPend_d = 1'b1;
        end else if (tickInRise) begin
            time_d.value = time_q.value + 6'h01;
            txTc_d = time_d;
            txTcPend_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            time_q <= TC_RESET;
            txTc_q <= TC_RESET;
            txTcPend_q <= 1'b0;
        end else begin
            time_q <= time_d;
            txTc_q <= txTc_d;
            txTcPend_q <= txTcPend_d;
        end
    end

    // ----------------------------------------
    // Tick output pulse
    // ----------------------------------------
    rlt_tick_e tick_q, tick_d;
    logic [CNT_W-1:0] tickCnt_q, tickCnt_d;
    rlt_tc_s tickVal_q, tickVal_d, tcOut_q, tcOut_d;
    logic tickPend_q, tickPend_d;

    always_comb begin
        tick_d = tick_q;
        tickCnt_d = tickCnt_q + 4'h1;
        tickVal_d = tickVal_q;
        tcOut_d = tcOut_q;
        tickPend_d = tickPend_q;
        if (extEvt) begin
            tickVal_d = rxTc_q;
            tickPend_d = 1'b1;
        end
        unique case (tick_q)
            TK_IDLE: begin
                tickCnt_d = 4'h0;
                if (tickPend_d) begin
                    tick_d = TK_HIGH;
                    tickPend_d = 1'b0;
                end
            end
            TK_HIGH: begin
                // four high then value at fall
                if (tickCnt_q == TICK_HIGH_LAST) begin
                    tick_d = TK_LOW;
                    tickCnt_d = 4'h0;
                    tcOut_d = tickVal_q;
                end
            end
            TK_LOW: begin
                if (tickCnt_q == TICK_LOW_LAST) begin
                    tick_d = TK_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_q <= TK_IDLE;
            tickCnt_q <= 4'h0;
            tickVal_q <= TC_RESET;
            tcOut_q <= TC_RESET;
            tickPend_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
            tickCnt_q <= tickCnt_d;
            tickVal_q <= tickVal_d;
            tcOut_q <= tcOut_d;
            tickPend_q <= tickPend_d;
        end
    end

    assign external_time_pulse_output = (tick_q == TK_HIGH);
    assign tcOutValue = tcOut_q;

    // ----------------------------------------
    // Serial transmitter
    // ----------------------------------------
    rlt_tx_e tx_q, tx_d;
    logic [CHAR_BITS-1:0] txShift_q, txShift_d;
    logic [CNT_W-1:0] txBit_q, txBit_d, txCyc_q, txCyc_d;
    logic txClk_q, txClk_d, txFrame_q, txFrame_d;

    always_comb begin
        tx_d = tx_q;
        txShift_d = txShift_q;
        txBit_d = txBit_q;
        txCyc_d = txCyc_q + 4'h1;
        txClk_d = txClk_q;
        txFrame_d = txFrame_q;
        txTcTake = 1'b0;
        extAPop = 1'b0;
        unique case (tx_q)
            TX_IDLE: begin
                txCyc_d = 4'h0;
                txBit_d = 4'h0;
                txFrame_d = 1'b0;
                if (txTcPend_q) begin
                    txShift_d = {1'b0, txTc_q, 1'b1};
                    txTcTake = 1'b1;
                    tx_d = TX_SEND;
                    txFrame_d = 1'b1;
                end else if (extAValid_q) begin
                    txShift_d = {extA_q, 1'b0};
                    extAPop = 1'b1;
                    tx_d = TX_SEND;
                    txFrame_d = 1'b1;
                end
            end
            TX_SEND: begin
                if (txCyc_q == HALF_CYC) begin
                    txClk_d = ~txClk_q;
                end
                if (txCyc_q == LAST_CYC) begin
                    txCyc_d = 4'h0;
                    txBit_d = txBit_q + 4'h1;
                    txShift_d = {1'b0, txShift_q[CHAR_BITS-1:1]};
                    if (txBit_q == LAST_BIT) begin
                        tx_d = TX_IDLE;
                        txFrame_d = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_q <= TX_IDLE;
            txShift_q <= 10'h000;
            txBit_q <= 4'h0;
            txCyc_q <= 4'h0;
            txClk_q <= 1'b0;
            txFrame_q <= 1'b0;
        end else begin
            tx_q <= tx_d;
            txShift_q <= txShift_d;
            txBit_q <= txBit_d;
            txCyc_q <= txCyc_d;
            txClk_q <= txClk_d;
            txFrame_q <= txFrame_d;
        end
    end

    assign txLinkClk = txClk_q;
    assign txLinkFrame = txFrame_q;
    assign txLinkBit = txShift_q[0];

endmodule

// ==== rlt_pkg.sv ====
package rlt_pkg;

    // ----------------------------------------
    // Clock and link timing
    // ----------------------------------------
    localparam int SYS_PERIOD_NS = 10;
    localparam int BIT_PERIOD_NS = 40;
    localparam int BIT_CYC = (BIT_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int BIT_HALF = BIT_CYC / 2;
    localparam int TICK_HIGH_CYC = 4;
    localparam int TICK_LOW_CYC = 3;

    // ----------------------------------------
    // Serial character layout
    // ----------------------------------------
    localparam int CHAR_BITS = 10;
    localparam int KIND_POS = 0;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] LAST_BIT = 4'h9;
    localparam logic [CNT_W-1:0] LAST_CYC = CNT_W'(BIT_CYC - 1);
    localparam logic [CNT_W-1:0] HALF_CYC = CNT_W'(BIT_HALF - 1);
    localparam logic [CNT_W-1:0] TICK_HIGH_LAST = CNT_W'(TICK_HIGH_CYC - 1);
    localparam logic [CNT_W-1:0] TICK_LOW_LAST = CNT_W'(TICK_LOW_CYC - 1);

    // ----------------------------------------
    // Output queue
    // ----------------------------------------
    localparam int FIFO_AW = 4;
    localparam int FIFO_DEPTH = 16;

    // ----------------------------------------
    // Carriers and reset values
    // ----------------------------------------
    typedef struct packed {
        logic eop;
        logic [7:0] data;
    } rlt_char_s;

    typedef struct packed {
        logic [1:0] flags;
        logic [5:0] value;
    } rlt_tc_s;

    localparam rlt_char_s CHAR_RESET = 9'h000;
    localparam rlt_tc_s TC_RESET = 8'h00;

    // ----------------------------------------
    // State machines
    // ----------------------------------------
    typedef enum logic [2:0] {
        ARB_IDLE = 3'b001,
        ARB_RX = 3'b010,
        ARB_EXT = 3'b100
    } rlt_arb_e;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } rlt_tx_e;

    typedef enum logic [2:0] {
        TK_IDLE = 3'b001,
        TK_HIGH = 3'b010,
        TK_LOW = 3'b100
    } rlt_tick_e;

    function automatic logic rose(input logic now, input logic was);
        rose = now & ~was;
    endfunction

endpackage

// ==== rlt_char_mem.sv ====
`timescale 1ns/1ps
module rlt_char_mem
    import rlt_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Write side
    input wire logic wrEn,
    input wire logic [FIFO_AW-1:0] wrAddr,
    input wire rlt_char_s wrData,
    // Read side
    input wire logic rdEn,
    input wire logic [FIFO_AW-1:0] rdAddr,
    output rlt_char_s rdData
);

    rlt_char_s store [FIFO_DEPTH];
    rlt_char_s rdData_q;

    always_ff @(posedge ref_clk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_q <= CHAR_RESET;
        end else if (rdEn) begin
            rdData_q <= store[rdAddr];
        end
    end

    assign rdData = rdData_q;

endmodule

// ==== rlt_link_partner.sv ====
`timescale 1ns/1ps
module rlt_link_partner
    import rlt_pkg::*;
(
    // Link into the receiver
    output logic rxLinkClk,
    output logic rxLinkFrame,
    output logic rxLinkBit,
    // Link from the transmitter
    input wire logic txLinkClk,
    input wire logic txLinkFrame,
    input wire logic txLinkBit,
    // Decoded characters
    output logic [9:0] txChar,
    output int txCount
);
    logic [9:0] shiftReg;
    int bitIdx;

    initial begin
        rxLinkClk = 1'b0;
        rxLinkFrame = 1'b0;
        rxLinkBit = 1'b1;
        txChar = 10'h000;
        txCount = 0;
        bitIdx = 0;
    end

    // one bit per link clock edge, 125 ns period
    task automatic send_char(input logic [9:0] c);
        #3.7;
        rxLinkFrame = 1'b1;
        for (int i = 0; i < CHAR_BITS; i++) begin
            rxLinkBit = c[i];
            #31.25;
            rxLinkClk = ~rxLinkClk;
            #31.25;
        end
        rxLinkFrame = 1'b0;
        rxLinkBit = ~c[CHAR_BITS-1];
    endtask

    always @(posedge txLinkFrame) begin
        bitIdx = 0;
    end

    // sample each bit at its link clock edge
    always @(txLinkClk) begin
        if (txLinkFrame === 1'b1 && bitIdx < CHAR_BITS) begin
            shiftReg[bitIdx] = txLinkBit;
            bitIdx = bitIdx + 1;
            if (bitIdx == CHAR_BITS) begin
                txChar = shiftReg;
                txCount = txCount + 1;
            end
        end
    end
endmodule

// ==== rlt_router_timing_chk.sv ====
`timescale 1ns/1ps
module rlt_router_timing_chk
    import rlt_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // External ports
    input wire logic extAWrEn,
    input wire logic extAFull,
    input wire logic extBWrEn,
    input wire logic extBFull,
    input wire logic extRdEn,
    input wire rlt_char_s extRdData,
    input wire logic extEmpty,
    // Time-code and transmitter
    input wire logic external_time_pulse_input,
    input wire logic external_time_pulse_output,
    input wire rlt_tc_s tcOutValue,
    input wire logic txLinkClk,
    input wire logic txLinkFrame
);
    logic [5:0] frameCnt_q;
    logic [5:0] frameCnt_d;

    always_comb begin
        frameCnt_d = txLinkFrame ? frameCnt_q + 6'h01 : 6'h00;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            frameCnt_q <= 6'h00;
        end else begin
            frameCnt_q <= frameCnt_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_tick_high;
        external_time_pulse_output [*4] ##1 !external_time_pulse_output;
    endsequence

    sequence s_tick_low;
        !external_time_pulse_output [*3];
    endsequence

    a_tick_high_four: assert property ($rose(external_time_pulse_output) |-> s_tick_high)
        else $error("tick pulse high time wrong");
    a_tick_low_three: assert property ($fell(external_time_pulse_output) |-> s_tick_low)
        else $error("tick pulse low time wrong");
    a_tc_at_fall: assert property ($changed(tcOutValue)
        |-> $fell(external_time_pulse_output))
        else $error("time value moved away from pulse fall");
    a_full_after_take: assert property (extAWrEn && !extAFull |=> extAFull)
        else $error("port A full not raised");
    a_b_not_empty: assert property (extBWrEn && !extBFull |-> ##[1:5] !extEmpty)
        else $error("port B write not seen at output");
    a_read_holds: assert property (!(extRdEn && !extEmpty) |=> $stable(extRdData))
        else $error("read data moved without a read");
    a_char_length: assert property ($fell(txLinkFrame) |-> frameCnt_q == 6'h28)
        else $error("transmit character length wrong");
    a_clk_in_frame: assert property ($changed(txLinkClk) |-> txLinkFrame)
        else $error("link clock moved outside a frame");
    a_tick_to_tx: assert property ($rose(external_time_pulse_input)
        |-> ##[1:134] $fell(txLinkFrame))
        else $error("tick input not sent in time");
    a_write_to_tx: assert property (extAWrEn && !extAFull |-> ##[1:188] $fell(txLinkFrame))
        else $error("port A char not sent in time");
endmodule

bind rlt_router_timing rlt_router_timing_chk u_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .extAWrEn(extAWrEn), .extAFull(extAFull),
    .extBWrEn(extBWrEn), .extBFull(extBFull), .extRdEn(extRdEn), .extRdData(extRdData),
    .extEmpty(extEmpty), .external_time_pulse_input(external_time_pulse_input),
    .external_time_pulse_output(external_time_pulse_output), .tcOutValue(tcOutValue),
    .txLinkClk(txLinkClk), .txLinkFrame(txLinkFrame)
);

// ==== rlt_router_timing_test.sv ====
`timescale 1ns/1ps
module rlt_router_timing_test
    import rlt_pkg::*;
;
    logic ref_clk, reset_n, extAWrEn, extAFull, extBWrEn, extBFull, extRdEn, extEmpty;
    logic external_time_pulse_input, time_counter_clear_input, tcExtEnable;
    logic external_time_pulse_output, rxClk, rxFrame, rxBit, txClk, txFrame, txBit;
    rlt_char_s extAWrData, extBWrData, extRdData, got, rdGot;
    rlt_tc_s tcOutValue;
    logic [9:0] txChar;
    logic [5:0] tcModel, tcShown;
    int txCount, txSeen, err_count, total_checks, cyc, t1;
    rlt_char_s extQ[$];
    logic [9:0] txQ[$];

    rlt_router_timing dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .extAWrEn(extAWrEn), .extAWrData(extAWrData),
        .extAFull(extAFull), .extBWrEn(extBWrEn), .extBWrData(extBWrData),
        .extBFull(extBFull), .extRdEn(extRdEn), .extRdData(extRdData), .extEmpty(extEmpty),
        .external_time_pulse_input(external_time_pulse_input),
        .time_counter_clear_input(time_counter_clear_input), .tcExtEnable(tcExtEnable),
        .external_time_pulse_output(external_time_pulse_output), .tcOutValue(tcOutValue),
        .rxLinkClk(rxClk), .rxLinkFrame(rxFrame), .rxLinkBit(rxBit),
        .txLinkClk(txClk), .txLinkFrame(txFrame), .txLinkBit(txBit)
    );

    rlt_link_partner link (
        .rxLinkClk(rxClk), .rxLinkFrame(rxFrame), .rxLinkBit(rxBit), .txLinkClk(txClk),
        .txLinkFrame(txFrame), .txLinkBit(txBit), .txChar(txChar), .txCount(txCount)
    );

    // ----------------------------------------
    // Clock, tasks and watchdog
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) cyc <= cyc + 1;

    task automatic check(input logic [31:0] gotV, input logic [31:0] expV);
        total_checks++;
        if (gotV !== expV) begin
            $display("unexpected at %0t: got %h expected %h", $time, gotV, expV);
            err_count++;
        end
    endtask

    task automatic give_verdict();
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Holds the write until an edge sees full low
    task automatic put(input logic toB, input rlt_char_s c);
        if (toB) begin
            extBWrEn <= 1'b1;
            extBWrData <= c;
            do @(posedge ref_clk); while (extBFull !== 1'b0);
        end else begin
            extAWrEn <= 1'b1;
            extAWrData <= c;
            do @(posedge ref_clk); while (extAFull !== 1'b0);
        end
    endtask

    task automatic read_one(output rlt_char_s c);
        extRdEn <= 1'b1;
        do @(posedge ref_clk); while (extEmpty !== 1'b0);
        extRdEn <= 1'b0;
        @(posedge ref_clk);
        c = extRdData;
    endtask

    task automatic pulse(input logic clr);
        if (clr) time_counter_clear_input <= 1'b1;
        else external_time_pulse_input <= 1'b1;
        repeat (3) @(posedge ref_clk);
        time_counter_clear_input <= 1'b0;
        external_time_pulse_input <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic expect_tx(input int since, input int limit);
        logic [9:0] expC;
        while (txCount == txSeen && cyc - since < limit + 2) @(posedge ref_clk);
        txSeen++;
        expC = txQ.pop_front();
        check({22'h0, txChar}, (cyc - since <= limit + 1) ? {22'h0, expC} : 32'hFFFF);
    endtask

    initial begin
        #100000;
        err_count++;
        give_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(98903));
        {err_count, total_checks, cyc, txSeen} = '0;
        {tcModel, tcShown} = '0;
        {reset_n, extAWrEn, extBWrEn, extRdEn, tcExtEnable} = '0;
        {external_time_pulse_input, time_counter_clear_input} = '0;
        extAWrData = CHAR_RESET;
        extBWrData = CHAR_RESET;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        check({extEmpty, extAFull, extBFull, external_time_pulse_output, txFrame, tcOutValue,
               extRdData}, 32'h00200000);
        repeat (2) @(posedge ref_clk);
        got = rlt_char_s'(9'($urandom));
        put(1'b1, got);
        extBWrEn <= 1'b0;
        extQ.push_back(got);
        t1 = cyc;
        while (extEmpty !== 1'b0 && cyc - t1 < 9) @(posedge ref_clk);
        check(32'(cyc - t1 <= 5), 32'h1);
        for (int i = 1; i < FIFO_DEPTH; i++) begin
            got = rlt_char_s'(9'($urandom));
            got.eop |= (i == FIFO_DEPTH - 1);
            put(1'b1, got);
            extQ.push_back(got);
        end
        extBWrEn <= 1'b0;
        while (extQ.size() > 0) begin
            read_one(got);
            check(32'(got), 32'(extQ.pop_front()));
        end
        extRdEn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        extRdEn <= 1'b0;
        check(32'({extEmpty, extRdData}), 32'({1'b1, got}));
        for (int i = 0; i < 3; i++) begin
            got = rlt_char_s'(9'($urandom));
            put(1'b0, got);
            txQ.push_back({got, 1'b0});
        end
        extAWrEn <= 1'b0;
        for (int i = 0; i < 3; i++) expect_tx(cyc, 188);
        for (int k = 0; k < 3; k++) begin
            if (k == 0) begin
                got = rlt_char_s'(9'($urandom));
                put(1'b0, got);
                extAWrEn <= 1'b0;
                txQ.push_back({got, 1'b0});
                while (txFrame !== 1'b1) @(posedge ref_clk);
            end
            if (k == 1) begin
                pulse(1'b1);
                tcModel = 6'h00;
            end
            t1 = cyc;
            pulse(1'b0);
            tcModel = tcModel + 6'h01;
            txQ.push_back({1'b0, 2'b00, tcModel, 1'b1});
            if (k == 0) expect_tx(t1, 134);
            expect_tx(t1, 134);
        end
        for (int k = 0; k < 3; k++) begin
            tcExtEnable <= (k == 1);
            @(posedge ref_clk);
            got = rlt_char_s'({1'b1, 8'($urandom)});
            tcModel = 6'($urandom);
            if (k == 0) link.send_char({got, 1'b0});
            else link.send_char({1'b0, 2'b00, tcModel, 1'b1});
            @(posedge ref_clk);
            t1 = cyc;
            if (k == 0) begin
                while (extEmpty !== 1'b0 && cyc - t1 < 75) @(posedge ref_clk);
                check(32'(cyc - t1 <= 67), 32'h1);
                read_one(rdGot);
                check(32'(rdGot), 32'(got));
            end else begin
                txQ.push_back({1'b0, 2'b00, tcModel, 1'b1});
                while (external_time_pulse_output !== 1'b1 && cyc - t1 < 100) @(posedge ref_clk);
                check({external_time_pulse_output, 1'(cyc - t1 <= 67)}, k == 1 ? 3 : 0);
                expect_tx(t1, 192);
                if (k == 1) tcShown = tcModel;
                check(32'(tcOutValue), 32'({2'b00, tcShown}));
            end
        end
        give_verdict();
    end
endmodule
